//--- dv/tb_universal_serial_shift_interface.sv
`timescale 1ns/100ps
`default_nettype none
module tb_universal_serial_shift_interface
  import ussi_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, regWe = 1'b0, regRe = 1'b0;
  logic        sleepIdle = 1'b0, sleepDeep = 1'b0, wakeReq, ovfFlag, startFlag;
  logic [1:0]  regAddr = 2'h0, bresp, rresp, r;
  logic [7:0]  regWdata = 8'h00, regRdata, v;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h0000_0000, rdata, q;
  int          err_total = 0, n_compared = 0;

  // Free-running system clock.
  always #10 clk = ~clk;

  ussi_link_if link ();
  ussi_dev_end u_ussi_dev_end (.clk(clk), .resetn(resetn), .link(link), .regAddr(regAddr),
    .regWe(regWe), .regRe(regRe), .regWdata(regWdata), .regRdata(regRdata),
    .timerMatch(1'b0), .sleepIdle(sleepIdle), .sleepDeep(sleepDeep), .wakeReq(wakeReq),
    .ovfFlag(ovfFlag), .startFlag(startFlag));
  ussi_host_end u_ussi_host_end (.clk(clk), .resetn(resetn), .link(link), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  ussi_link_asserts u_ussi_link_asserts (.clk(clk), .resetn(resetn), .devClkO(link.devClkO),
    .devClkOe(link.devClkOe), .devAO(link.devAO), .hostClkO(link.hostClkO),
    .hostClkOe(link.hostClkOe), .hostBO(link.hostBO), .hostBOe(link.hostBOe),
    .clkLine(link.clkLine), .lineA(link.lineA));

  // Prints the verdict and ends the run.
  task stop_test;
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // Counts a wait that ran out and ends the run.
  task tmo;
    err_total++;
    $display("BAD %0t wait limit reached", $time);
    stop_test();
  endtask : tmo

  // Compares one byte-wide result.
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk

  // Writes one device register with a single-cycle strobe.
  task dw(input logic [1:0] a, input logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWe <= 1'b1;
    @(posedge clk);
    regWe <= 1'b0;
    @(posedge clk);
  endtask : dw

  // Reads one device register; data is valid one cycle after the strobe.
  task dr(input logic [1:0] a, output logic [7:0] d);
    regAddr <= a;
    regRe <= 1'b1;
    @(posedge clk);
    regRe <= 1'b0;
    @(negedge clk);
    d = regRdata;
    @(posedge clk);
  endtask : dr

  // One AXI4-Lite write or read; readiness seen mid-cycle is acted on at the next edge.
  task axi(input logic wr, input logic [3:0] a, input logic [31:0] d,
           output logic [31:0] dq, output logic [1:0] rs);
    logic pa, pw, pr, done;
    int n;
    pa = wr; pw = wr; pr = !wr; done = 1'b0; n = 0;
    awaddr <= a; araddr <= a; wdata <= d;
    awvalid <= wr; wvalid <= wr; bready <= wr; arvalid <= !wr; rready <= !wr;
    while (!done && n < 200) begin
      @(negedge clk);
      if (awready) pa = 1'b0;
      if (wready) pw = 1'b0;
      if (arready) pr = 1'b0;
      done = wr ? bvalid : rvalid;
      dq = rdata;
      rs = wr ? bresp : rresp;
      @(posedge clk);
      awvalid <= pa; wvalid <= pw; arvalid <= pr;
      bready <= wr && !done; rready <= !wr && !done;
      n++;
    end
    // Let an edge pass so a following call never reassigns in this step.
    @(posedge clk);
    if (!done) tmo();
  endtask : axi

  // Polls the host status until the link transfer is over.
  task hidle(output logic [31:0] s);
    int n;
    n = 0;
    s = 32'hFFFF_FFFF;
    while (s[0] !== 1'b0 && n < 300) begin
      axi(1'b0, HOST_STAT, 32'h0000_0000, s, r);
      n++;
    end
    if (n == 300) tmo();
  endtask : hidle

  // Waits for the overflow flag (sel high) or the start flag.
  task wflag(input logic sel);
    int n;
    n = 0;
    while ((sel ? ovfFlag : startFlag) !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    if (n == 2000) tmo();
  endtask : wflag

  // Unmapped host addresses answer with an error.
  task t_axi;
    axi(1'b0, 4'hC, 32'h0000_0000, q, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
    chk(q[7:0], 8'h00);
    axi(1'b1, 4'hC, 32'h0000_0001, q, r);
    chk({6'h0, r}, {6'h0, RESP_SLVERR});
  endtask : t_axi

  // Three-wire byte exchange, mode 0, then wake and flag clearing.
  task t_three;
    dw(REG_PORT, 8'h0A);
    dw(REG_CTRL, 8'h18);
    dw(REG_STAT, 8'hC0);
    dw(REG_DATA, 8'hA5);
    sleepIdle <= 1'b1;
    axi(1'b1, HOST_TX, 32'h0000_003C, q, r);
    axi(1'b1, HOST_CMD, 32'h0000_0001, q, r);
    hidle(q);
    chk(q[15:8], 8'hA5);
    dr(REG_DATA, v);
    chk(v, 8'h3C);
    dr(REG_STAT, v);
    chk(v, 8'hC0);
    chk({7'h0, wakeReq}, 8'h01);
    sleepIdle <= 1'b0;
    sleepDeep <= 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h0, wakeReq}, 8'h00);
    sleepDeep <= 1'b0;
    dw(REG_STAT, 8'h40);
    dr(REG_STAT, v);
    chk(v, 8'h80);
  endtask : t_three

  // Software strobes count and toggle the clock pin.
  task t_swclk;
    dw(REG_PORT, 8'h0F);
    dw(REG_STAT, 8'hC0);
    repeat (3) dw(REG_CTRL, 8'h1B);
    dr(REG_STAT, v);
    chk(v, 8'h83);
    chk({7'h0, link.devClkO}, 8'h00);
  endtask : t_swclk

  // Two-wire address byte with start hold, overflow hold and acknowledge.
  task t_two;
    dw(REG_CTRL, 8'h38);
    dw(REG_PORT, 8'h07);
    dw(REG_DATA, 8'hFF);
    dw(REG_STAT, 8'hC0);
    axi(1'b1, HOST_TX, 32'h0000_00A4, q, r);
    axi(1'b1, HOST_CMD, 32'h0000_0007, q, r);
    wflag(1'b0);
    chk({7'h0, startFlag}, 8'h01);
    repeat (40) @(posedge clk);
    chk({7'h0, link.clkLine}, 8'h00);
    dw(REG_STAT, 8'h80);
    wflag(1'b1);
    dr(REG_DATA, v);
    chk(v, 8'hA4);
    repeat (20) @(posedge clk);
    chk({7'h0, link.clkLine}, 8'h00);
    dw(REG_DATA, 8'h00);
    dw(REG_PORT, 8'h0F);
    dw(REG_STAT, 8'h4E);
    wflag(1'b1);
    hidle(q);
    chk({7'h0, q[1]}, 8'h01);
    dw(REG_PORT, 8'h07);
    dw(REG_STAT, 8'h40);
  endtask : t_two

  // Reset, then the scenarios in turn.
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_axi();
    t_three();
    t_swclk();
    t_two();
    stop_test();
  end
endmodule : tb_universal_serial_shift_interface
`default_nettype wire

//--- dv/ussi_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module ussi_link_asserts (
  input wire logic clk,
  input wire logic resetn,
  input wire logic devClkO,
  input wire logic devClkOe,
  input wire logic devAO,
  input wire logic hostClkO,
  input wire logic hostClkOe,
  input wire logic hostBO,
  input wire logic hostBOe,
  input wire logic clkLine,
  input wire logic lineA
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Device pull state and host release state on the shared clock line.
  logic devPull;
  logic hostRel;
  assign devPull = devClkOe & ~devClkO;
  assign hostRel = ~hostClkOe | hostClkO;

  clk_high_min_a: assert property ($rose(hostRel) |-> hostRel [*4])
    else $error("clock high phase too short");
  clk_low_min_a: assert property ($fell(hostRel) |-> !hostRel [*4])
    else $error("clock low phase too short");
  host_wait_a: assert property (hostRel && !clkLine |=> hostRel)
    else $error("master moved on while clock held low");
  host_fall_a: assert property ($fell(hostRel) |-> $past(clkLine))
    else $error("master pulled clock without seeing it high");
  stretch_start_a: assert property ($rose(devPull) |-> !$past(clkLine))
    else $error("stretch began while clock high");
  clk_rise_src_a: assert property ($rose(clkLine) |-> hostRel)
    else $error("clock rose without the master");
  dev_data_hold_a: assert property ($rose(clkLine) |=> $stable(devAO) [*3])
    else $error("device data moved in clock high phase");
  host_setup_a: assert property ($changed(hostBO) && hostBOe |-> !hostClkO [*3])
    else $error("master data setup too short");

  // Main scenarios reached.
  cover property ($rose(devPull));
  cover property ($fell(lineA) && clkLine);
  cover property (hostRel && !clkLine ##1 clkLine);
endmodule : ussi_link_asserts
`default_nettype wire

//--- rtl/ussi_dev_end.sv
`timescale 1ns/100ps
`default_nettype none
module ussi_dev_end
  import ussi_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  ussi_link_if.dev        link,
  input  wire logic [1:0] regAddr,
  input  wire logic       regWe,
  input  wire logic       regRe,
  input  wire logic [7:0] regWdata,
  output logic      [7:0] regRdata,
  input  wire logic       timerMatch,
  input  wire logic       sleepIdle,
  input  wire logic       sleepDeep,
  output logic            wakeReq,
  output logic            ovfFlag,
  output logic            startFlag
);
  typedef struct packed {
    logic [7:0]       ctrl;
    logic             cntOnTog;
    logic [7:0]       shreg;
    logic [CNT_W-1:0] cnt;
    logic             oif;
    logic             sif;
    logic [7:0]       port;
    logic             doLatch;
    logic             latchOpen;
    logic             clkPrev;
    logic             aPrev;
    logic             clkHold;
    logic             wake;
    logic [7:0]       rdata;
  } ussi_dev_t;

  ussi_dev_t st_r;
  ussi_dev_t st_nxt;

  logic [1:0] lineSync;
  logic       clkS;
  logic       aS;
  logic       bS;
  logic [1:0] bSyncQ;

  // Pins come from another domain and pass two flip-flops first.
  ussi_sync #(.W(2)) syncPins (
    .clk    (clk),
    .resetn (resetn),
    .d      ({link.clkLine, link.lineA}),
    .q      (lineSync)
  );
  ussi_sync #(.W(2)) syncDin (
    .clk    (clk),
    .resetn (resetn),
    .d      ({link.lineB, 1'b0}),
    .q      (bSyncQ)
  );
  assign clkS = lineSync[1];
  assign aS   = lineSync[0];
  assign bS   = bSyncQ[1];

  logic [1:0] wm;
  logic       twoWire;
  logic       threeWire;
  logic       ext;
  logic       edgeSel;
  logic       clkRise;
  logic       clkFall;
  logic       sampleEdge;
  logic       shiftEdge;
  logic       wrCtl;
  logic       wrStat;
  logic       wrData;
  logic       wrPort;
  logic       togW;
  logic       swW;
  logic       shiftTick;
  logic       countTick;
  logic       diBit;
  logic       cntTog;

  // Mode decode, edge detection and clock source selection.
  assign wm         = {st_r.ctrl[CTL_WM1_BIT], st_r.ctrl[CTL_WM0_BIT]};
  assign twoWire    = wm[1];
  assign threeWire  = (wm == 2'b01);
  assign ext        = st_r.ctrl[CTL_EXT_BIT];
  assign edgeSel    = st_r.ctrl[CTL_EDGE_BIT];
  assign clkRise    = clkS & ~st_r.clkPrev;
  assign clkFall    = ~clkS & st_r.clkPrev;
  assign sampleEdge = ext & (edgeSel ? clkFall : clkRise);
  assign shiftEdge  = ext & (edgeSel ? clkRise : clkFall);
  assign wrCtl      = regWe & (regAddr == REG_CTRL);
  assign wrStat     = regWe & (regAddr == REG_STAT);
  assign wrData     = regWe & (regAddr == REG_DATA);
  assign wrPort     = regWe & (regAddr == REG_PORT);
  assign togW       = wrCtl & regWdata[CTL_TOG_BIT];
  assign swW        = wrCtl & regWdata[CTL_SWCLK_BIT];
  assign diBit      = twoWire ? aS : bS;
  // Internal sources: software strobe or timer match
  assign shiftTick  = ext ? sampleEdge : (edgeSel ? timerMatch : swW);
  // With the external clock already selected, the write that selects strobe counting counts its own toggle strobe.
  assign cntTog     = wrCtl ? (regWdata[CTL_SWCLK_BIT] & regWdata[CTL_EXT_BIT])
                            : st_r.cntOnTog;
  assign countTick  = ext ? (cntTog ? togW : (clkRise | clkFall))
                          : (edgeSel ? timerMatch : swW);

  always_comb begin
    st_nxt         = st_r;
    st_nxt.clkPrev = clkS;
    st_nxt.aPrev   = aS;

    // Control write; strobe bits are not stored.
    if (wrCtl) begin
      st_nxt.ctrl     = regWdata & CTRL_WMASK;
      st_nxt.cntOnTog = regWdata[CTL_SWCLK_BIT] & regWdata[CTL_EXT_BIT];
    end

    // Port register; a toggle strobe flips the clock output bit.
    if (wrPort) begin
      st_nxt.port = regWdata;
    end
    if (togW) begin
      st_nxt.port[PORT_CLK_OUT_BIT] = ~st_nxt.port[PORT_CLK_OUT_BIT];
    end

    // A data write wins over a shift in the same cycle.
    if (wrData) begin
      st_nxt.shreg = regWdata;
    end else if (shiftTick) begin
      st_nxt.shreg = {st_r.shreg[6:0], diBit};
    end

    // Counter: a status write loads it, else the tick advances it.
    if (wrStat) begin
      st_nxt.cnt = regWdata[CNT_W-1:0];
    end else if (countTick) begin
      st_nxt.cnt = CNT_W'(st_r.cnt + 4'h1);
    end

    // Sticky flags: a set in the clearing cycle wins.
    st_nxt.oif = (countTick & (st_r.cnt == CNT_MAX))
               | (st_r.oif & ~(wrStat & regWdata[STAT_OIF_BIT]));
    st_nxt.sif = (twoWire & clkS & st_r.clkPrev & st_r.aPrev & ~aS)
               | (threeWire & countTick)
               | (st_r.sif & ~(wrStat & regWdata[STAT_SIF_BIT]));

    // Clock stretch: start hold, and overflow hold in mode 3, once line low.
    st_nxt.clkHold = twoWire & (st_r.sif | (wm[0] & st_r.oif))
                   & (st_r.clkHold | ~clkS);

    // Output latch open from change edge to sample edge, always if internal.
    if (!ext) begin
      st_nxt.latchOpen = 1'b1;
    end else if (shiftEdge) begin
      st_nxt.latchOpen = 1'b1;
    end else if (sampleEdge) begin
      st_nxt.latchOpen = 1'b0;
    end
    if (st_nxt.latchOpen) begin
      st_nxt.doLatch = st_nxt.shreg[7];
    end

    // Overflow wakes only from idle; start wakes from any sleep, in two-wire mode only.
    st_nxt.wake = (st_r.oif & sleepIdle)
                | (st_r.sif & twoWire & (sleepIdle | sleepDeep));

    // Read data is captured on the read strobe.
    if (regRe) begin
      unique case (regAddr)
        REG_CTRL: st_nxt.rdata = st_r.ctrl;
        REG_STAT: st_nxt.rdata = {st_r.sif, st_r.oif, 2'b00, st_r.cnt};
        REG_DATA: st_nxt.rdata = st_r.shreg;
        REG_PORT: st_nxt.rdata = st_r.port;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r           <= '0;
      st_r.ctrl      <= CTRL_RST;
      st_r.shreg     <= SHREG_RST;
      st_r.cnt       <= CNT_RST;
      st_r.port      <= PORT_RST;
      st_r.latchOpen <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin drivers: open drain in two-wire mode, push-pull otherwise.
  always_comb begin
    if (twoWire) begin
      link.devClkO  = 1'b0;
      link.devClkOe = (st_r.port[PORT_CLK_DIR_BIT] & ~st_r.port[PORT_CLK_OUT_BIT])
                    | st_r.clkHold;
      link.devAO    = 1'b0;
      link.devAOe   = st_r.port[PORT_DO_DIR_BIT]
                    & ~(st_r.doLatch & st_r.port[PORT_DO_OUT_BIT]);
    end else begin
      link.devClkO  = st_r.port[PORT_CLK_OUT_BIT];
      link.devClkOe = st_r.port[PORT_CLK_DIR_BIT];
      link.devAO    = threeWire ? st_r.doLatch : st_r.port[PORT_DO_OUT_BIT];
      link.devAOe   = st_r.port[PORT_DO_DIR_BIT];
    end
  end

  assign regRdata  = st_r.rdata;
  assign wakeReq   = st_r.wake;
  assign ovfFlag   = st_r.oif;
  assign startFlag = st_r.sif;
endmodule : ussi_dev_end
`default_nettype wire

//--- rtl/ussi_host_end.sv
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ussi_host_end
  import ussi_pkg::*;
#(
  parameter int HALF_CYC = LINK_HALF_CYC
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  ussi_link_if.host        link,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  typedef enum logic [2:0] {H_IDLE, H_RSTA, H_START, H_LOW, H_HIGH, H_STOP, H_STOP2}
    ussi_hstate_t;
  typedef struct packed {
    ussi_hstate_t state;
    logic [7:0]   tmr;
    logic [3:0]   bitCnt;
    logic [7:0]   tx;
    logic [7:0]   sh;
    logic [7:0]   rx;
    logic         ack;
    logic         two;
    logic         rd;
    logic         stop;
    logic         clkO;
    logic         aO;
    logic         awHeld;
    logic [3:0]   awAddr;
    logic         wHeld;
    logic [7:0]   wData;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
  } ussi_host_t;

  localparam logic [7:0] HALF = 8'(HALF_CYC);

  ussi_host_t st_r;
  ussi_host_t st_nxt;
  logic [1:0] lineSync;
  logic       clkS;
  logic       aS;

  ussi_sync #(.W(2)) syncPins (
    .clk    (clk),
    .resetn (resetn),
    .d      ({link.clkLine, link.lineA}),
    .q      (lineSync)
  );
  assign clkS = lineSync[1];
  assign aS   = lineSync[0];

  always_comb begin
    logic go;
    logic busy;
    logic [3:0] lastBit;
    go      = 1'b0;
    busy    = (st_r.state != H_IDLE);
    lastBit = st_r.two ? ACK_SLOT : 4'h7;
    st_nxt  = st_r;

    // AXI4-Lite write: address and data taken in either order.
    if (awvalid & ~st_r.awHeld) begin
      st_nxt.awHeld = 1'b1;
      st_nxt.awAddr = awaddr;
    end
    if (wvalid & ~st_r.wHeld) begin
      st_nxt.wHeld = 1'b1;
      st_nxt.wData = wstrb[0] ? wdata[7:0] : 8'h00;
    end
    if (st_r.bvalid & bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.awHeld & st_r.wHeld & ~st_r.bvalid) begin
      st_nxt.awHeld = 1'b0;
      st_nxt.wHeld  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = RESP_OKAY;
      unique case (st_r.awAddr)
        HOST_CMD: begin
          if (!busy) begin
            go          = st_r.wData[HC_GO_BIT];
            st_nxt.two  = st_r.wData[HC_TWO_BIT];
            st_nxt.rd   = st_r.wData[HC_RD_BIT];
            st_nxt.stop = st_r.wData[HC_STOP_BIT];
            st_nxt.clkO = st_r.wData[HC_TWO_BIT];
          end
        end
        HOST_TX: begin
          if (!busy) begin
            st_nxt.tx = st_r.wData;
          end
        end
        HOST_STAT: ;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end

    // AXI4-Lite read.
    if (st_r.rvalid & rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (arvalid & ~st_r.rvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = RESP_OKAY;
      unique case (araddr)
        HOST_CMD:  st_nxt.rdata = {27'h000_0000, st_r.rd, st_r.stop, 1'b0, st_r.two, busy};
        HOST_TX:   st_nxt.rdata = {24'h00_0000, st_r.tx};
        HOST_STAT: st_nxt.rdata = {16'h0000, st_r.rx, 6'h00, st_r.ack, busy};
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Serial master sequencer.
    unique case (st_r.state)
      H_IDLE: begin
        if (go) begin
          st_nxt.sh     = st_r.tx;
          st_nxt.bitCnt = 4'h0;
          st_nxt.tmr    = HALF;
          if (st_nxt.two & st_r.wData[HC_START_BIT]) begin
            st_nxt.state = H_RSTA;
            st_nxt.clkO  = 1'b1;
            st_nxt.aO    = 1'b1;
          end else begin
            st_nxt.state = H_LOW;
            st_nxt.clkO  = 1'b0;
          end
        end
      end
      H_RSTA: begin
        if (clkS) begin
          if (st_r.tmr == 8'h00) begin
            st_nxt.aO    = 1'b0;
            st_nxt.tmr   = HALF;
            st_nxt.state = H_START;
          end else begin
            st_nxt.tmr = st_r.tmr - 8'h01;
          end
        end
      end
      H_START: begin
        if (st_r.tmr == 8'h00) begin
          st_nxt.clkO  = 1'b0;
          st_nxt.tmr   = HALF;
          st_nxt.state = H_LOW;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      H_LOW: begin
        // Data changes just after the falling edge, a half period before sampling.
        if (st_r.tmr == HALF) begin
          if (st_r.bitCnt == ACK_SLOT) begin
            st_nxt.aO = st_r.rd ? st_r.stop : 1'b1;
          end else begin
            st_nxt.aO = st_r.rd ? 1'b1 : st_r.sh[7];
          end
        end
        if (st_r.tmr == 8'h00) begin
          st_nxt.clkO  = 1'b1;
          st_nxt.tmr   = HALF;
          st_nxt.state = H_HIGH;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      H_HIGH: begin
        // Wait for the line itself to rise; a slave may stretch it.
        if (clkS) begin
          if (st_r.tmr == 8'h00) begin
            if (st_r.bitCnt == ACK_SLOT) begin
              st_nxt.ack = ~aS;
            end else begin
              st_nxt.rx = {st_r.rx[6:0], aS};
              st_nxt.sh = {st_r.sh[6:0], 1'b0};
            end
            st_nxt.clkO = 1'b0;
            st_nxt.tmr  = HALF;
            if (st_r.bitCnt == lastBit) begin
              st_nxt.state = (st_r.two & st_r.stop) ? H_STOP : H_IDLE;
            end else begin
              st_nxt.bitCnt = st_r.bitCnt + 4'h1;
              st_nxt.state  = H_LOW;
            end
          end else begin
            st_nxt.tmr = st_r.tmr - 8'h01;
          end
        end
      end
      H_STOP: begin
        if (st_r.tmr == HALF) begin
          st_nxt.aO = 1'b0;
        end
        if (st_r.tmr == 8'h00) begin
          st_nxt.clkO  = 1'b1;
          st_nxt.tmr   = HALF;
          st_nxt.state = H_STOP2;
        end else begin
          st_nxt.tmr = st_r.tmr - 8'h01;
        end
      end
      H_STOP2: begin
        if (clkS) begin
          if (st_r.tmr == 8'h00) begin
            st_nxt.aO    = 1'b1;
            st_nxt.state = H_IDLE;
          end else begin
            st_nxt.tmr = st_r.tmr - 8'h01;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r       <= '0;
      st_r.state <= H_IDLE;
      st_r.aO    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Two-wire lines are open drain; three-wire drives clock and host data out.
  assign link.hostClkO  = st_r.two ? 1'b0 : st_r.clkO;
  assign link.hostClkOe = st_r.two ? ~st_r.clkO : 1'b1;
  assign link.hostAO    = 1'b0;
  assign link.hostAOe   = st_r.two & ~st_r.aO;
  assign link.hostBO    = st_r.sh[7];
  assign link.hostBOe   = ~st_r.two;

  assign awready = ~st_r.awHeld;
  assign wready  = ~st_r.wHeld;
  assign bvalid  = st_r.bvalid;
  assign bresp   = st_r.bresp;
  assign arready = ~st_r.rvalid;
  assign rvalid  = st_r.rvalid;
  assign rdata   = st_r.rdata;
  assign rresp   = st_r.rresp;
endmodule : ussi_host_end
`default_nettype wire

//--- rtl/ussi_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ussi_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ussi_sync_t;

  ussi_sync_t st_r;
  ussi_sync_t st_nxt;

  // Two stages; only the second stage is visible outside.
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : ussi_sync
`default_nettype wire

//--- shared/ussi_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ussi_link_if;
  // Per-end pin drivers; a low drive with enable pulls the shared wire low.
  logic devClkO;
  logic devClkOe;
  logic devAO;
  logic devAOe;
  logic hostClkO;
  logic hostClkOe;
  logic hostAO;
  logic hostAOe;
  logic hostBO;
  logic hostBOe;
  logic clkLine;
  logic lineA;
  logic lineB;

  // Wired-AND with pull-up models both push-pull and open-drain use.
  assign clkLine = (~devClkOe | devClkO) & (~hostClkOe | hostClkO);
  assign lineA   = (~devAOe | devAO) & (~hostAOe | hostAO);
  assign lineB   = ~hostBOe | hostBO;

  modport dev (output devClkO, devClkOe, devAO, devAOe,
               input clkLine, lineA, lineB);
  modport host (output hostClkO, hostClkOe, hostAO, hostAOe, hostBO, hostBOe,
                input clkLine, lineA);
endinterface : ussi_link_if
`default_nettype wire

//--- shared/ussi_pkg.sv
package ussi_pkg;

  // System clock rate.
  localparam int CLK_HZ = 50_000_000;

  // Device register indices on the device's own register port.
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_DATA = 2'h2;
  localparam logic [1:0] REG_PORT = 2'h3;

  // Control register fields.
  localparam int CTL_TOG_BIT   = 0;
  localparam int CTL_SWCLK_BIT = 1;
  localparam int CTL_EDGE_BIT  = 2;
  localparam int CTL_EXT_BIT   = 3;
  localparam int CTL_WM0_BIT   = 4;
  localparam int CTL_WM1_BIT   = 5;
  localparam logic [7:0] CTRL_WMASK = 8'h3C;

  // Status register fields.
  localparam int STAT_OIF_BIT = 6;
  localparam int STAT_SIF_BIT = 7;

  // Port register fields: output values and direction bits.
  localparam int PORT_CLK_OUT_BIT = 0;
  localparam int PORT_DO_OUT_BIT  = 1;
  localparam int PORT_CLK_DIR_BIT = 2;
  localparam int PORT_DO_DIR_BIT  = 3;

  // Reset values.
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] SHREG_RST = 8'h00;
  localparam logic [3:0] CNT_RST   = 4'h0;
  localparam logic [7:0] PORT_RST  = 8'h03;

  // Counter width and its last value before overflow.
  localparam int         CNT_W   = 4;
  localparam logic [3:0] CNT_MAX = 4'hF;

  // Host command register map, byte addresses on AXI4-Lite.
  localparam logic [3:0] HOST_CMD  = 4'h0;
  localparam logic [3:0] HOST_TX   = 4'h4;
  localparam logic [3:0] HOST_STAT = 4'h8;
  localparam int HC_GO_BIT    = 0;
  localparam int HC_TWO_BIT   = 1;
  localparam int HC_START_BIT = 2;
  localparam int HC_STOP_BIT  = 3;
  localparam int HC_RD_BIT    = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Half period of the host-made serial clock.
  localparam int LINK_HALF_NS  = 80;
  localparam int LINK_HALF_CYC = LINK_HALF_NS * (CLK_HZ / 1_000_000) / 1000;

  // Bit index of the acknowledge slot in a two-wire byte.
  localparam logic [3:0] ACK_SLOT = 4'h8;

endpackage : ussi_pkg
